// *** verilog/ddp_cfg.svh ***
// Addresses, field positions and reset values for the pointer unit
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH

`define DDP_ADDR_PTR_LO 8'h82
`define DDP_ADDR_PTR_HI 8'h83
`define DDP_ADDR_CTRL 8'h85
`define DDP_ADDR_MODE 8'h86

`define DDP_CTRL_SEL_BIT 0
`define DDP_CTRL_TOGGLE_BIT 6
`define DDP_CTRL_RESET 8'h00
`define DDP_MODE_RESET 8'h00
`define DDP_PTR_RESET 16'h0000

`define DDP_MODE_ZERO_LSB 0
`define DDP_MODE_ONE_LSB 2

`endif

// *** verilog/ddp_pkg.sv ***
// Types shared by the pointer unit
package ddp_pkg;
  typedef enum logic [1:0] {
    DDP_HOLD = 2'h0,
    DDP_RSVD = 2'h1,
    DDP_INC = 2'h2,
    DDP_DEC = 2'h3
  } ddp_mode_t;
endpackage : ddp_pkg

// *** verilog/ddp_pointer_unit.sv ***
// Dual external-data pointer unit with special-register access
`timescale 1ns/1ns
`default_nettype none
`include "ddp_cfg.svh"

module ddp_pointer_unit
  import ddp_pkg::*;
#(
  parameter int PTR_WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Special-register bus from the core
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrRead,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // External-data move completion from the core
  input wire logic extMoveDone,
  // Address presented to the external memory space
  output logic [PTR_WIDTH-1:0] activePointer,
  output logic pointerSelect
);

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire logic rstN = rstSync_reg;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [PTR_WIDTH-1:0] ptr_reg [2];
  logic [PTR_WIDTH-1:0] ptr_next [2];
  logic sel_reg;
  logic sel_next;
  logic toggle_reg;
  logic toggle_next;
  logic [3:0] mode_reg;
  logic [3:0] mode_next;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = `DDP_CTRL_RESET;
  localparam logic [7:0] MODE_RST = `DDP_MODE_RESET;
  localparam logic [PTR_WIDTH-1:0] PTR_ONE = PTR_WIDTH'(1);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire logic hitLo = sfrAddr == `DDP_ADDR_PTR_LO;
  wire logic hitHi = sfrAddr == `DDP_ADDR_PTR_HI;
  wire logic hitCtrl = sfrAddr == `DDP_ADDR_CTRL;
  wire logic hitMode = sfrAddr == `DDP_ADDR_MODE;
  wire logic anyHit = hitLo | hitHi | hitCtrl | hitMode;
  wire logic wrCtrl = sfrWrite & hitCtrl;
  wire logic wrMode = sfrWrite & hitMode;
  wire logic wrLo = sfrWrite & hitLo;
  wire logic wrHi = sfrWrite & hitHi;
  // A control write owns the select bit in its cycle; a move only flips it
  // when no control write is in the same cycle, so software always has the last word
  wire logic selFlip = extMoveDone & toggle_reg & ~wrCtrl;

  // Only the selected pointer is ever visible
  wire logic [PTR_WIDTH-1:0] selPtr = ptr_reg[sel_reg];
  wire logic [7:0] ctrlView = {1'b0, toggle_reg, 5'h00, sel_reg};
  wire logic [7:0] rdMux =
    hitLo ? selPtr[7:0] :
    hitHi ? selPtr[15:8] :
    hitCtrl ? ctrlView :
    hitMode ? {4'h0, mode_reg} : 8'h00;

  // ------------------------------------------------------------
  // Next-state: write first, then post-move adjust and toggle
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      // This pointer is the one the core sees through 82h/83h
      wire logic mine = sel_reg == 1'(gi);
      wire ddp_mode_t md = ddp_mode_t'(mode_reg[2*gi +: 2]);
      wire logic wrLoMine = mine & wrLo;
      wire logic wrHiMine = mine & wrHi;
      // Reserved mode is not decoded, so it falls through to hold
      wire logic incMine = mine & extMoveDone & (md == DDP_INC);
      wire logic decMine = mine & extMoveDone & (md == DDP_DEC);
      wire logic [PTR_WIDTH-1:0] incVal = ptr_reg[gi] + PTR_ONE;
      wire logic [PTR_WIDTH-1:0] decVal = ptr_reg[gi] - PTR_ONE;
      always_comb begin
        ptr_next[gi] = ptr_reg[gi];
        if (wrLoMine) begin
          ptr_next[gi][7:0] = sfrWdata;
        end
        if (wrHiMine) begin
          ptr_next[gi][15:8] = sfrWdata;
        end
        // Adjust only the pointer the move used
        // A byte write in the same cycle loses to the adjust
        if (incMine) begin
          ptr_next[gi] = incVal;
        end else if (decMine) begin
          ptr_next[gi] = decVal;
        end
      end
    end
  endgenerate

  always_comb begin
    sel_next = sel_reg;
    toggle_next = toggle_reg;
    mode_next = mode_reg;
    if (wrCtrl) begin
      sel_next = sfrWdata[`DDP_CTRL_SEL_BIT];
      toggle_next = sfrWdata[`DDP_CTRL_TOGGLE_BIT];
    end else if (selFlip) begin
      sel_next = ~sel_reg;
    end
    if (wrMode) begin
      mode_next = sfrWdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ptr_reg[0] <= `DDP_PTR_RESET;
      ptr_reg[1] <= `DDP_PTR_RESET;
      sel_reg <= CTRL_RST[`DDP_CTRL_SEL_BIT];
      toggle_reg <= CTRL_RST[`DDP_CTRL_TOGGLE_BIT];
      mode_reg <= MODE_RST[3:0];
    end else begin
      ptr_reg[0] <= ptr_next[0];
      ptr_reg[1] <= ptr_next[1];
      sel_reg <= sel_next;
      toggle_reg <= toggle_next;
      mode_reg <= mode_next;
    end
  end

  // Outputs registered; activePointer and pointerSelect show the state after each edge
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sfrRdata <= 8'h00;
      sfrHit <= 1'b0;
      activePointer <= `DDP_PTR_RESET;
      pointerSelect <= 1'b0;
    end else begin
      sfrRdata <= sfrRead ? rdMux : 8'h00;
      sfrHit <= (sfrRead | sfrWrite) & anyHit;
      activePointer <= ptr_next[sel_next];
      pointerSelect <= sel_next;
    end
  end

endmodule : ddp_pointer_unit
`default_nettype wire

// *** bench/ddp_checker.sv ***
// Port assertions for the pointer unit
`timescale 1ns/1ns
`default_nettype none
module ddp_checker #(parameter int PTR_WIDTH = 16) (
  input wire logic sys_clk, nrst, sfrWrite, sfrRead, sfrHit, extMoveDone,
  input wire logic pointerSelect, input wire logic [7:0] sfrAddr, sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic [PTR_WIDTH-1:0] activePointer);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic ctl = sfrAddr == 8'h85;
  wire logic idle = !sfrWrite && !extMoveDone;
  a_rd_idle:
    assert property (!sfrRead |=> sfrRdata == 0) else $error("rdata");
  a_hit_ctl:
    assert property (sfrRead && ctl |=> sfrHit) else $error("hit");
  a_sel_write:
    assert property (sfrWrite && ctl |=> pointerSelect == $past(sfrWdata[0]))
      else $error("select");
  a_sel_hold:
    assert property (idle |=> $stable(pointerSelect)) else $error("flip");
  a_ctl_rsvd:
    assert property (sfrRead && ctl |=> (sfrRdata & 8'hBE) == 0)
      else $error("rsvd");
  a_ctl_read:
    assert property (sfrRead && ctl |=> sfrRdata[0] == $past(pointerSelect))
      else $error("sel read");
  a_ptr_hold:
    assert property (idle |=> $stable(activePointer)) else $error("ptr");
  a_ptr_write:
    assert property (sfrWrite && sfrAddr == 8'h82 && !extMoveDone |=>
      activePointer[7:0] == $past(sfrWdata)) else $error("ptr write");
  c_move: cover property (extMoveDone);
  c_flip: cover property (pointerSelect ##1 !pointerSelect);
  c_mode: cover property (sfrWrite && sfrAddr == 8'h86);
endmodule : ddp_checker
bind ddp_pointer_unit ddp_checker #(.PTR_WIDTH(PTR_WIDTH)) chk_i (.*);
`default_nettype wire

// *** bench/ddp_core_model.sv ***
// Core-side model: register accesses and move pulses
`timescale 1ns/1ns
`default_nettype none
module ddp_core_model (
  input wire logic sys_clk, sfrHit,
  input wire logic [7:0] sfrRdata,
  output logic sfrWrite, sfrRead, extMoveDone,
  output logic [7:0] sfrAddr, sfrWdata);
  logic [8:0] q;
  initial {sfrWrite, sfrRead, extMoveDone, sfrAddr, sfrWdata} = '0;
  task op(input logic [2:0] k, input logic [7:0] ad, d);
    @(negedge sys_clk);
    {sfrWrite, sfrRead, extMoveDone, sfrAddr, sfrWdata} = {k, ad, d};
    @(negedge sys_clk);
    q = {sfrHit, sfrRdata};
    // Data inverted once released, so a late capture shows up
    {sfrWrite, sfrRead, extMoveDone, sfrWdata} = {3'b000, ~d};
  endtask : op
endmodule : ddp_core_model
`default_nettype wire

// *** bench/tb_dual_data_pointer_unit.sv ***
// Self-checking bench for the pointer unit
`timescale 1ns/1ns
`default_nettype none
module tb_dual_data_pointer_unit;
  logic sys_clk = 0, nrst = 0, sfrWrite, sfrRead, sfrHit, extMoveDone;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic [15:0] activePointer;
  logic pointerSelect;
  int mismatches = 0, num_checks = 0;
  // Kind (4 write, 2 read, 1 move), address, data, expected result
  localparam logic [35:0] STEPS [22] = '{
    36'h285000100, 36'h483121200, 36'h485FF0000,
    36'h285000141, 36'h483ABAB00, 36'h2830001AB,
    36'h282000100, 36'h485401200, 36'h283000112,
    36'h486FE1200, 36'h28600010E, 36'h10000AB00,
    36'h100001201, 36'h282000101, 36'h485001201,
    36'h100001202, 36'h482FF12FF, 36'h483FFFFFF,
    36'h100000000, 36'h486010000, 36'h100000000,
    36'h284000000
  };
  // Expected select bit after each step, first step leftmost
  localparam logic [0:21] SEL_EXP = 22'b0011111000010000000000;
  always #5 sys_clk = ~sys_clk;
  ddp_core_model m (.*);
  ddp_pointer_unit uut (.*);
  task chk(input string n, input logic [15:0] s, e);
    num_checks++;
    mismatches += int'(s !== e);
    if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
  endtask : chk
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    #5000 mismatches++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1;
    repeat (2) @(negedge sys_clk);
    foreach (STEPS[i]) begin
      m.op(STEPS[i][34:32], STEPS[i][31:24], STEPS[i][23:16]);
      chk("step", STEPS[i][33] ? {7'h00, m.q} : activePointer,
          STEPS[i][15:0]);
      chk("select", {15'h0000, pointerSelect},
          {15'h0000, SEL_EXP[i]});
    end
    conclude();
  end
endmodule : tb_dual_data_pointer_unit
`default_nettype wire
